// ===== logic/universal_output_control.sv
`timescale 1ns/100ps
`include "uoc_defines.svh"
module universal_output_control #(
   parameter int TICK_CYCLES = `UOC_TICK_CYC
) (
   input wire logic clock_in, // System clock, 100 MHz
   input wire logic rst_in, // Asynchronous reset, active high
   input wire logic hsel_in, // AHB slave select
   input wire logic [31:0] haddr_in, // AHB address
   input wire logic [1:0] htrans_in, // AHB transfer type
   input wire logic hwrite_in, // AHB write
   input wire logic [2:0] hsize_in, // AHB size, word only
   input wire logic [31:0] hwdata_in, // AHB write data
   input wire logic hready_in, // AHB bus ready
   output logic [31:0] hrdata_out, // AHB read data
   output logic hreadyout_out, // AHB slave ready
   output logic hresp_out, // AHB response, always OKAY
   input wire logic [15:0] meas0_in, // Measured input 0
   input wire logic [15:0] meas1_in, // Measured input 1
   input wire logic enable_in, // Enable signal
   input wire logic override_in, // Override signal
   input wire logic ctrl_fault_in, // Control input fault
   input wire logic en_fault_in, // Enable input fault
   input wire logic ovr_fault_in, // Override input fault
   input wire logic pwr_fault_in, // Supply over/under voltage
   input wire logic otemp_in, // Over-temperature reading
   input wire logic [15:0] feedback_in, // Measured output feedback
   output uoc_pkg::drive_t drive_out, // Converter and timer drive
   output logic out_fault_out // Feedback mismatch flag
);

   if (TICK_CYCLES < 1 || TICK_CYCLES > 131071) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end

   // Linear map of x over [xlo,xhi] onto [ylo,yhi], x clamped
   function automatic logic [15:0] lin(input logic [15:0] x, input logic [15:0] xlo,
         input logic [15:0] xhi, input logic [15:0] ylo, input logic [15:0] yhi);
      logic signed [17:0] dx;
      logic signed [17:0] span;
      logic signed [17:0] dy;
      logic signed [35:0] q;
      if (xhi <= xlo) return ylo;
      span = $signed({2'b00, xhi}) - $signed({2'b00, xlo});
      dy = $signed({2'b00, yhi}) - $signed({2'b00, ylo});
      if (x <= xlo) dx = '0;
      else if (x >= xhi) dx = span;
      else dx = $signed({2'b00, x}) - $signed({2'b00, xlo});
      q = (dy * dx) / 36'(span);
      return 16'(q + 36'($signed({2'b00, ylo})));
   endfunction : lin

   // Ramp step per tick: output span over ramp time, at least 1
   function automatic logic [15:0] rstep(input logic [15:0] lo, input logic [15:0] hi,
         input logic [15:0] ms);
      logic [15:0] span;
      logic [15:0] q;
      span = (hi > lo) ? hi - lo : lo - hi;
      q = (ms == 16'h0000) ? span : span / ms;
      return (q == 16'h0000) ? 16'h0001 : q;
   endfunction : rstep

   uoc_pkg::st_t st;
   uoc_pkg::st_t nx;
   uoc_pkg::ctrl_t cc;
   uoc_pkg::filt_t fc;
   logic [1:0][15:0] raw;
   logic [15:0] ctrl_x;
   logic [15:0] freq_x;
   logic en_on;
   logic en_act;
   logic ovr_act;
   logic flt;
   logic shut_now;
   logic [5:0] idx;
   logic [31:0] rdv;

   // Decoded views of configuration and the active input conditions
   assign cc = uoc_pkg::ctrl_t'(st.rw[`UOC_R_CTRL]);
   assign fc = uoc_pkg::filt_t'(st.rw[`UOC_R_FILT]);
   assign raw[0] = meas0_in;
   assign raw[1] = meas1_in;
   assign ctrl_x = lin(st.filt[cc.ctrl_sel], st.rw[`UOC_R_INRNG][15:0],
      st.rw[`UOC_R_INRNG][31:16], 16'h0000, 16'hffff);
   assign freq_x = lin(st.filt[cc.freq_sel], st.rw[`UOC_R_INRNG][15:0],
      st.rw[`UOC_R_INRNG][31:16], 16'h0000, 16'hffff);
   assign en_on = cc.en_used ? enable_in : 1'b1;
   assign en_act = (cc.en_resp == 3'h2 || cc.en_resp == 3'h3) ? !en_on : en_on;
   assign ovr_act = cc.ovr_used && (cc.ovr_resp ? !override_in : override_in);
   assign flt = ctrl_fault_in || (cc.en_used && en_fault_in)
      || (cc.ovr_used && ovr_fault_in);
   assign shut_now = (cc.pwr_en && pwr_fault_in) || (cc.otemp_en && otemp_in);
   // Addresses above 0xff decode to 63 and read as zero
   assign idx = (haddr_in[31:8] == 24'h000000) ? haddr_in[7:2] : 6'h3f;

   // Read mux; a write still in its data phase is forwarded
   always_comb begin
      rdv = 32'h00000000;
      if (idx < 6'(`UOC_NRW)) rdv = st.rw[idx[3:0]];
      else if (idx == `UOC_R_STAT)
         rdv = {12'h000, st.fault_det, st.shut, cc.ctrl_dig, st.dig, st.outv};
      else if (idx == `UOC_R_FILTV) rdv = {st.filt[1], st.filt[0]};
      if (st.a_valid && st.a_write && st.a_idx == idx && idx < 6'(`UOC_NRW)) rdv = hwdata_in;
   end

   // Next state of the whole block
   always_comb begin
      logic c;
      logic dg;
      logic immed;
      logic [7:0] k;
      logic [23:0] s;
      logic signed [16:0] d;
      logic [15:0] tgt;
      logic [15:0] step;
      logic [15:0] fbd;
      c = 1'b0;
      dg = 1'b0;
      immed = 1'b0;
      k = 8'h01;
      s = 24'h000000;
      d = '0;
      tgt = 16'h0000;
      step = 16'h0000;
      fbd = 16'h0000;
      nx = st;
      nx.tick = 1'b0;
      // Millisecond tick divider
      if (st.tick_cnt == 17'(TICK_CYCLES - 1)) begin
         nx.tick_cnt = '0;
         nx.tick = 1'b1;
      end else begin
         nx.tick_cnt = st.tick_cnt + 17'h00001;
      end
      // AHB data phase: perform a pending write
      if (st.a_valid && st.a_write && st.a_idx < 6'(`UOC_NRW)) begin
         nx.rw[st.a_idx[3:0]] = hwdata_in;
         if (st.a_idx == `UOC_R_CTRL && hwdata_in[7:0] != cc.out_type) begin
            nx.rw[`UOC_R_FIX] = {16'h0000, (hwdata_in[7:0] == `UOC_OT_PWM) ?
               `UOC_FIX_FREQ_DEF : `UOC_FIX_DUTY_DEF};
         end
      end
      nx.a_valid = 1'b0;
      // AHB address phase: zero wait states, read data prepared now
      if (hsel_in && hready_in && htrans_in[1]) begin
         nx.a_valid = 1'b1;
         nx.a_write = hwrite_in;
         nx.a_idx = idx;
         nx.hrdata = hwrite_in ? 32'h00000000 : rdv;
      end
      if (st.tick) begin
         // Input filters, one reading per tick
         for (int i = 0; i < 2; i++) begin
            k = (fc.fconst[i] == 8'h00) ? 8'h01 : fc.fconst[i];
            case (fc.ftype[i])
               `UOC_F_MOV: begin
                  d = $signed({1'b0, raw[i]}) - $signed({1'b0, st.filt[i]});
                  nx.filt[i] = st.filt[i] + 16'(d / $signed({9'h000, k}));
               end
               `UOC_F_REP: begin
                  s = st.sum[i] + {8'h00, raw[i]};
                  if (st.cnt[i] + 8'h01 >= k) begin
                     nx.filt[i] = 16'(s / {16'h0000, k});
                     nx.sum[i] = 24'h000000;
                     nx.cnt[i] = 8'h00;
                  end else begin
                     nx.sum[i] = s;
                     nx.cnt[i] = st.cnt[i] + 8'h01;
                  end
               end
               default: nx.filt[i] = raw[i];
            endcase
         end
         // Command state: digital source or hysteresis band
         if (cc.ctrl_dig) c = st.filt[cc.ctrl_sel] != 16'h0000;
         else if (ctrl_x <= st.rw[`UOC_R_XRNG][15:0]) c = 1'b0;
         else if (ctrl_x >= st.rw[`UOC_R_XRNG][31:16]) c = 1'b1;
         else c = st.cmd;
         nx.cmd = c;
         dg = st.dig;
         // Digital response selected by code
         case (cc.dig_resp)
            `UOC_D_INV: dg = !c;
            `UOC_D_LATCH: if (c && !st.cmd) dg = !st.dig;
            `UOC_D_BLINK: begin
               if (!c) begin
                  dg = 1'b0;
                  nx.blink_cnt = 16'h0000;
               end else if (st.blink_cnt + 16'h0001 >= st.rw[`UOC_R_DIG][31:16]) begin
                  dg = !st.dig;
                  nx.blink_cnt = 16'h0000;
               end else begin
                  nx.blink_cnt = st.blink_cnt + 16'h0001;
               end
            end
            default: begin
               // Delay only the edge chosen by polarity; 0 ms means none
               if (c == st.dig) begin
                  nx.dly_cnt = 16'h0000;
               end else if (st.rw[`UOC_R_DIG][15:0] == 16'h0000 || c == cc.delay_pol) begin
                  dg = c;
                  nx.dly_cnt = 16'h0000;
               end else if (st.dly_cnt + 16'h0001 >= st.rw[`UOC_R_DIG][15:0]) begin
                  dg = c;
                  nx.dly_cnt = 16'h0000;
               end else begin
                  nx.dly_cnt = st.dly_cnt + 16'h0001;
               end
            end
         endcase
         nx.dig = dg;
         // Priority: shutdown, input fault, override, enable, control
         if (shut_now) begin
            immed = 1'b1;
         end else if (flt) begin
            immed = 1'b1;
            case (cc.fault_resp)
               `UOC_FR_VAL: tgt = st.rw[`UOC_R_VALS][31:16];
               `UOC_FR_HOLD: tgt = st.outv;
               default: tgt = 16'h0000;
            endcase
         end else if (ovr_act) begin
            tgt = st.rw[`UOC_R_VALS][15:0];
            immed = 1'b1;
         end else if (!en_act) begin
            case (cc.en_resp)
               3'h4: tgt = st.rw[`UOC_R_YRNG][15:0];
               3'h5: tgt = st.rw[`UOC_R_YRNG][31:16];
               3'h1, 3'h3: tgt = 16'h0000;
               default: immed = 1'b1;
            endcase
         end else if (cc.out_type == `UOC_OT_DIG) begin
            tgt = dg ? 16'hffff : 16'h0000;
         end else begin
            tgt = lin(ctrl_x, st.rw[`UOC_R_XRNG][15:0], st.rw[`UOC_R_XRNG][31:16],
               st.rw[`UOC_R_YRNG][15:0], st.rw[`UOC_R_YRNG][31:16]);
         end
         if (cc.out_type == `UOC_OT_DIG) immed = 1'b1;
         // Ramp towards the target at the configured rate
         if (immed || tgt == st.outv) begin
            nx.outv = tgt;
         end else if (tgt > st.outv) begin
            step = rstep(st.rw[`UOC_R_YRNG][15:0], st.rw[`UOC_R_YRNG][31:16],
               st.rw[`UOC_R_RAMP][15:0]);
            nx.outv = (st.rw[`UOC_R_RAMP][15:0] == 16'h0000 || tgt - st.outv <= step) ?
               tgt : st.outv + step;
         end else begin
            step = rstep(st.rw[`UOC_R_YRNG][15:0], st.rw[`UOC_R_YRNG][31:16],
               st.rw[`UOC_R_RAMP][31:16]);
            nx.outv = (st.rw[`UOC_R_RAMP][31:16] == 16'h0000 || st.outv - tgt <= step) ?
               tgt : st.outv - step;
         end
         nx.shut = shut_now;
         // Drive mapping per output type
         nx.drive = '0;
         if (!shut_now) begin
            case (cc.out_type)
               `UOC_OT_V5, `UOC_OT_V10, `UOC_OT_I20, `UOC_OT_I420: begin
                  nx.drive.dac_value = nx.outv;
                  nx.drive.dac_en = 1'b1;
               end
               `UOC_OT_FREQ: begin
                  nx.drive.tmr_freq = nx.outv;
                  nx.drive.tmr_duty = st.rw[`UOC_R_FIX][15:0];
                  nx.drive.tmr_en = 1'b1;
               end
               `UOC_OT_PWM: begin
                  nx.drive.tmr_duty = nx.outv;
                  nx.drive.tmr_freq = st.rw[`UOC_R_FIX][15:0];
                  nx.drive.tmr_en = 1'b1;
               end
               `UOC_OT_DIG: begin
                  nx.drive.dig = nx.outv != 16'h0000;
                  nx.drive.tmr_duty = nx.outv;
                  nx.drive.tmr_en = 1'b1;
               end
               `UOC_OT_MIX: begin
                  nx.drive.tmr_duty = nx.outv;
                  nx.drive.tmr_freq = lin(freq_x, 16'h0000, 16'hffff,
                     st.rw[`UOC_R_MIXF][15:0], st.rw[`UOC_R_MIXF][31:16]);
                  nx.drive.tmr_en = 1'b1;
               end
               default: nx.drive = '0;
            endcase
         end
         // Feedback against demand; a stage that is off never flags
         fbd = (feedback_in > nx.outv) ? feedback_in - nx.outv : nx.outv - feedback_in;
         nx.fault_det = (nx.drive.dac_en || nx.drive.tmr_en)
            && fbd > st.rw[`UOC_R_FBTOL][15:0];
      end
   end

   // State register; reset clears everything, the bus stays ready
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
         st.hready <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign hrdata_out = st.hrdata;
   assign hreadyout_out = st.hready;
   assign hresp_out = st.hresp;
   assign drive_out = st.drive;
   assign out_fault_out = st.fault_det;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   property p_pwr;
      st.tick && cc.pwr_en && pwr_fault_in |=> st.outv == 16'h0000 && !drive_out.dac_en
         && !drive_out.tmr_en;
   endproperty
   a_pwr: assert property (p_pwr) else $error("power fault did not disable output");
   property p_otemp;
      st.tick && cc.otemp_en && otemp_in |=> st.shut && drive_out == '0;
   endproperty
   a_otemp: assert property (p_otemp) else $error("over-temp did not disable");
   property p_ovr;
      st.tick && !shut_now && !flt && ovr_act |=> st.outv == $past(st.rw[`UOC_R_VALS][15:0]);
   endproperty
   a_ovr: assert property (p_ovr) else $error("override value not driven");
   property p_fval;
      st.tick && !shut_now && flt && cc.fault_resp == `UOC_FR_VAL
         |=> st.outv == $past(st.rw[`UOC_R_VALS][31:16]);
   endproperty
   a_fval: assert property (p_fval) else $error("fault value not driven");
   property p_fhold;
      st.tick && !shut_now && flt && cc.fault_resp == `UOC_FR_HOLD
         |=> st.outv == $past(st.outv);
   endproperty
   a_fhold: assert property (p_fhold) else $error("hold last value failed");
   property p_enoff;
      st.tick && !shut_now && !flt && !ovr_act && !en_act && cc.en_resp == 3'h0
         |=> st.outv == 16'h0000;
   endproperty
   a_enoff: assert property (p_enoff) else $error("enable shutoff failed");
   property p_latch;
      st.tick && cc.dig_resp == `UOC_D_LATCH && st.cmd == nx.cmd |=> $stable(st.dig);
   endproperty
   a_latch: assert property (p_latch) else $error("latched output changed");
   property p_blink;
      st.tick && cc.dig_resp == `UOC_D_BLINK && !nx.cmd |=> !st.dig;
   endproperty
   a_blink: assert property (p_blink) else $error("blink output not off");
   property p_off;
      st.tick && cc.out_type == `UOC_OT_OFF |=> drive_out == '0;
   endproperty
   a_off: assert property (p_off) else $error("disabled type drives");
   property p_fix;
      st.a_valid && st.a_write && st.a_idx == `UOC_R_CTRL && hwdata_in[7:0] == `UOC_OT_PWM
         && cc.out_type != `UOC_OT_PWM |=> st.rw[`UOC_R_FIX][15:0] == `UOC_FIX_FREQ_DEF;
   endproperty
   a_fix: assert property (p_fix) else $error("fixed parameter not defaulted");

   c_ramp: cover property (st.tick && st.outv != nx.outv && !shut_now ##1 st.outv != 16'h0000);
   c_blink: cover property (st.tick && cc.dig_resp == `UOC_D_BLINK && nx.dig != st.dig);
   c_mix: cover property (drive_out.tmr_en && cc.out_type == `UOC_OT_MIX);
   c_fb: cover property (out_fault_out);
endmodule : universal_output_control

// ===== logic/uoc_defines.svh
`ifndef UOC_DEFINES_SVH
`define UOC_DEFINES_SVH
// Timing: 1 ms control tick from a 10 ns clock
`define UOC_CLK_NS 10
`define UOC_TICK_US 1000
`define UOC_TICK_CYC ((`UOC_TICK_US * 1000) / `UOC_CLK_NS)
// Register word indices (byte address = index * 4)
`define UOC_R_CTRL 6'h00
`define UOC_R_FILT 6'h01
`define UOC_R_XRNG 6'h02
`define UOC_R_YRNG 6'h03
`define UOC_R_RAMP 6'h04
`define UOC_R_DIG 6'h05
`define UOC_R_VALS 6'h06
`define UOC_R_FIX 6'h07
`define UOC_R_MIXF 6'h08
`define UOC_R_INRNG 6'h09
`define UOC_R_FBTOL 6'h0a
`define UOC_R_STAT 6'h0b
`define UOC_R_FILTV 6'h0c
`define UOC_NRW 11
// Output type codes
`define UOC_OT_OFF 8'h00
`define UOC_OT_V5 8'h0c
`define UOC_OT_V10 8'h0d
`define UOC_OT_I20 8'h14
`define UOC_OT_I420 8'h15
`define UOC_OT_FREQ 8'h28
`define UOC_OT_PWM 8'h32
`define UOC_OT_DIG 8'h3c
`define UOC_OT_MIX 8'h46
// Filter, digital response and fault response codes
`define UOC_F_NONE 2'h0
`define UOC_F_MOV 2'h1
`define UOC_F_REP 2'h2
`define UOC_D_NORM 2'h0
`define UOC_D_INV 2'h1
`define UOC_D_LATCH 2'h2
`define UOC_D_BLINK 2'h3
`define UOC_FR_OFF 2'h0
`define UOC_FR_VAL 2'h1
`define UOC_FR_HOLD 2'h2
// Fixed-parameter defaults applied on an output type change
`define UOC_FIX_DUTY_DEF 16'h8000
`define UOC_FIX_FREQ_DEF 16'h01f4
`endif

// ===== logic/uoc_pkg.sv
`include "uoc_defines.svh"
package uoc_pkg;
   // Layout of the control register, msb first
   typedef struct packed {
      logic [7:0] pad;
      logic ctrl_dig;
      logic freq_sel;
      logic ctrl_sel;
      logic ovr_used;
      logic en_used;
      logic otemp_en;
      logic pwr_en;
      logic [1:0] fault_resp;
      logic ovr_resp;
      logic [2:0] en_resp;
      logic delay_pol;
      logic [1:0] dig_resp;
      logic [7:0] out_type;
   } ctrl_t;
   // Layout of the filter register
   typedef struct packed {
      logic [11:0] pad;
      logic [1:0][1:0] ftype;
      logic [1:0][7:0] fconst;
   } filt_t;
   // Drive towards converter and timer stages
   typedef struct packed {
      logic [15:0] dac_value;
      logic dac_en;
      logic [15:0] tmr_freq;
      logic [15:0] tmr_duty;
      logic tmr_en;
      logic dig;
   } drive_t;
   // Whole state of the block
   typedef struct packed {
      logic [`UOC_NRW-1:0][31:0] rw;
      logic [16:0] tick_cnt;
      logic tick;
      logic a_valid;
      logic a_write;
      logic [5:0] a_idx;
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
      logic [1:0][15:0] filt;
      logic [1:0][23:0] sum;
      logic [1:0][7:0] cnt;
      logic [15:0] outv;
      logic cmd;
      logic dig;
      logic [15:0] dly_cnt;
      logic [15:0] blink_cnt;
      logic shut;
      logic fault_det;
      drive_t drive;
   } st_t;
endpackage : uoc_pkg

// ===== tb/output_stage_model.sv
`timescale 1ns/100ps
// Converter stage: reports the DAC level it drives, plus an injected error; timer drive reads back zero
module output_stage_model (
   input wire logic clock_in, // System clock
   input wire logic rst_in, // Reset, active high
   input uoc_pkg::drive_t drive_in, // Drive from the block
   input wire logic [15:0] err_in, // Feedback error to inject
   output logic [15:0] feedback_out // Measured output feedback
);
   // A disabled stage reads back zero, so stale drive values never look healthy
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         feedback_out <= 16'h0000;
      end else begin
         feedback_out <= drive_in.dac_en ? drive_in.dac_value + err_in : 16'h0000;
      end
   end
endmodule : output_stage_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic [15:0] meas0 = 16'h0000;
   logic [15:0] err = 16'h0000;
   logic [15:0] fb;
   logic [4:0] flt = 5'h00; // enable, override, ctrl fault, pwr fault, otemp
   uoc_pkg::drive_t drv;
   logic fault;
   uoc_pkg::ctrl_t c;
   logic [31:0] rd;
   logic d1;
   int n_errors = 0;
   int n_tests = 0;
   logic [7:0] ot [8] = '{8'h00, 8'h0c, 8'h0d, 8'h14, 8'h15, 8'h28, 8'h32, 8'h46};
   universal_output_control #(.TICK_CYCLES(10)) universal_output_control_inst (
      .clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .meas0_in(meas0), .meas1_in(16'h0000), .enable_in(flt[4]), .override_in(flt[3]),
      .ctrl_fault_in(flt[2]), .en_fault_in(1'b0), .ovr_fault_in(1'b0),
      .pwr_fault_in(flt[1]), .otemp_in(flt[0]), .feedback_in(fb), .drive_out(drv),
      .out_fault_out(fault));
   output_stage_model output_stage_model_inst (.clock_in(clock_in), .rst_in(rst_in),
      .drive_in(drv), .err_in(err), .feedback_out(fb));
   // Clock at 100 MHz
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   task give_verdict;
      $display("errors %0d of %0d comparisons", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One AHB single transfer; waits on hready in both phases
   task bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, idx, 2'b00};
      hwrite <= wr;
      n = 0;
      do begin @(posedge clock_in); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      n = 0;
      do begin @(posedge clock_in); n++; end while (hready !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) n_errors++;
   endtask : bus
   task rdc(input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h00000000);
      chk(rd, exp);
   endtask : rdc
   // Waits n control ticks plus slack so the result has been published
   task tk(input int n);
      repeat (n * 10 + 3) @(posedge clock_in);
   endtask : tk
   task setc;
      bus(1'b1, 6'h00, 32'(c));
      tk(3);
   endtask : setc
   // Watchdog well above the expected run of about 1350 cycles
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      rdc(6'h0b, 32'h00000000);
      chk({31'h0, hresp}, 32'h0);
      bus(1'b1, 6'h09, 32'hffff0000);
      bus(1'b1, 6'h02, 32'hffff0000);
      bus(1'b1, 6'h03, 32'hffff0000);
      rdc(6'h03, 32'hffff0000);
      rdc(6'h3f, 32'h00000000);
      // Every output type except digital selects its stage and restores the fixed parameter
      meas0 <= 16'hffff;
      c = '0;
      for (int i = 7; i >= 0; i--) begin
         bus(1'b1, 6'h07, 32'h00001234);
         c.out_type = ot[i];
         setc();
         rdc(6'h07, (ot[i] == 8'h32) ? 32'h000001f4 : 32'h00008000);
         chk({drv.dac_en, drv.tmr_en}, {30'h0, ot[i] inside {[8'h0c:8'h15]},
            ot[i] > 8'h15});
      end
      c.out_type = 8'h0c;
      setc();
      // Status bit 16 is the digital state, which follows the command and is high with full-scale input
      rdc(6'h0b, 32'h0001ffff);
      chk(drv.dac_value, 32'h0000ffff);
      bus(1'b1, 6'h03, 32'h0000ffff);
      tk(2);
      rdc(6'h0b, 32'h00010000);
      // Ramp from 0 up to full scale over 4 ms
      bus(1'b1, 6'h04, 32'h00000004);
      bus(1'b1, 6'h03, 32'hffff0000);
      tk(1);
      bus(1'b0, 6'h0b, 32'h0);
      chk({31'h0, rd[15:0] != 16'h0000 && rd[15:0] != 16'hffff}, 32'h1);
      tk(5);
      rdc(6'h0b, 32'h0001ffff);
      bus(1'b1, 6'h0a, 32'h00000010);
      bus(1'b1, 6'h06, 32'h12345678);
      tk(2);
      chk({31'h0, fault}, 32'h0);
      err <= 16'h0100;
      tk(2);
      chk({31'h0, fault}, 32'h1);
      err <= 16'h0000;
      // Override, then an input fault that must win over it
      c.ovr_used = 1'b1;
      flt <= 5'h08;
      setc();
      rdc(6'h0b, 32'h00015678);
      c.fault_resp = 2'h1;
      flt <= 5'h0c;
      setc();
      bus(1'b0, 6'h0b, 32'h0);
      chk(rd[15:0], 32'h00001234);
      c.pwr_en = 1'b1;
      c.otemp_en = 1'b1;
      flt <= 5'h02;
      setc();
      chk({drv.dac_en, drv.tmr_en}, 32'h0);
      flt <= 5'h01;
      tk(2);
      chk({31'h0, drv.dac_en}, 32'h0);
      flt <= 5'h00;
      tk(2);
      chk({31'h0, drv.dac_en}, 32'h1);
      c.en_used = 1'b1;
      setc();
      rdc(6'h0b, 32'h00010000);
      c.en_resp = 3'h2;
      setc();
      // The 4 ms up ramp still applies, so allow it to finish
      tk(3);
      rdc(6'h0b, 32'h0001ffff);
      // Digital output driven from an analog control with hysteresis
      bus(1'b1, 6'h02, 32'hc0004000);
      bus(1'b1, 6'h03, 32'hc0004000);
      c = '0;
      c.out_type = 8'h3c;
      setc();
      chk({31'h0, drv.dig}, 32'h1);
      meas0 <= 16'h8000;
      tk(2);
      chk({31'h0, drv.dig}, 32'h1);
      meas0 <= 16'h0000;
      tk(2);
      chk({31'h0, drv.dig}, 32'h0);
      c.dig_resp = 2'h1;
      setc();
      chk({31'h0, drv.dig}, 32'h1);
      c.dig_resp = 2'h2;
      setc();
      meas0 <= 16'hffff;
      tk(2);
      d1 = drv.dig;
      meas0 <= 16'h0000;
      tk(2);
      chk({31'h0, drv.dig}, {31'h0, d1});
      meas0 <= 16'hffff;
      tk(2);
      chk({31'h0, drv.dig}, {31'h0, ~d1});
      // Blink every tick: exactly ten clocks later the output is inverted
      bus(1'b1, 6'h05, 32'h00010000);
      c.dig_resp = 2'h3;
      setc();
      @(posedge clock_in);
      #1 d1 = drv.dig;
      repeat (10) @(posedge clock_in);
      #1 chk({31'h0, drv.dig}, {31'h0, ~d1});
      meas0 <= 16'h0000;
      tk(2);
      chk({31'h0, drv.dig}, 32'h0);
      // Repeating average of a constant reading publishes that reading
      meas0 <= 16'h0400;
      bus(1'b1, 6'h01, 32'h00020004);
      tk(6);
      rdc(6'h0c, 32'h00000400);
      // Moving average with constant 2 settles one count short of the input
      meas0 <= 16'h0800;
      bus(1'b1, 6'h01, 32'h00010002);
      tk(20);
      rdc(6'h0c, 32'h000007ff);
      give_verdict();
   end
endmodule : tb_top
